// ===== hw/bag_gain_ctrl.sv
// Gain control with battery tracking limiter, source mux and edge decode
//
// Contract
// (RULE_01) The 5-bit gain code maps linearly in 1 dB steps from -7 dB at 0 to +24 dB at 31.
// (RULE_02) Exactly one source, analog or digital, reaches the amplifier, never a mix.
// (RULE_03) Gain is lowered only when the output level exceeds the limit, never for battery alone; the code also lowers it at once to a reduced fixed_gain_i.
// (RULE_04) Above the inflection point the peak limit follows the boost voltage.
// (RULE_05) The inflection point is an 8-bit field at offset 0x0B, 3.0 V plus 17.33 mV per code.
// (RULE_06) Below the inflection point the limit falls by a slope from offset 0x0C, 1.2 V/V + 37.3 mV/V per code.
// (RULE_07) While the signal exceeds the limit, gain keeps stepping down at the attack rate.
// (RULE_08) While below the limit and under the fixed gain, gain steps up at the release rate.
// (RULE_09) Attack step time is a 3-bit code at 0x0E, 20 us per dB plus 350 per code.
// (RULE_10) Release step time is a 4-bit code at 0x0F, 50 ms per dB plus 105 per code.
// (RULE_11) A 3-bit edge code selects switching edges from about 50 ns down to about 11 ns.
// (RULE_12) Gain moves 1 dB each time the selected step interval, counted on the clock, elapses.
// (RULE_13) Gain never exceeds the fixed gain and starts from it after reset.
`timescale 1ns/1ps
module bag_gain_ctrl #(
  parameter int unsigned ATK_BASE_CYC = bag_pkg::ATK_BASE_CYC,
  parameter int unsigned ATK_STEP_CYC = bag_pkg::ATK_STEP_CYC,
  parameter int unsigned REL_BASE_CYC = bag_pkg::REL_BASE_CYC,
  parameter int unsigned REL_STEP_CYC = bag_pkg::REL_STEP_CYC
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  // Static configuration
  input  wire logic [4:0]  fixed_gain_i,
  input  wire logic        src_digital_i,
  input  wire logic [2:0]  edge_slew_control_i,
  // Audio sources
  input  wire logic [15:0] analog_sample_i,
  input  wire logic [15:0] digital_sample_i,
  // Supply and level monitors, in mV
  input  wire logic [15:0] vbat_mv_i,
  input  wire logic [15:0] vboost_mv_i,
  input  wire logic [15:0] out_peak_mv_i,
  // Amplifier side
  output logic      [15:0] spk_sample_o,
  output logic      [4:0]  gain_code_o,
  output logic signed [5:0] gain_db_o,
  output logic      [15:0] peak_output_limit_o,
  output logic      [5:0]  edge_time_ns_o,
  output logic             agc_active_o
);

  localparam int unsigned TW = bag_pkg::TIMER_W;

  typedef struct packed {
    bag_pkg::bag_agc_st_t             st;
    logic [bag_pkg::GAIN_W-1:0]       cur_gain;
    logic [bag_pkg::LEVEL_W-1:0]      limit_mv;
    logic [7:0]                       infl;
    logic [7:0]                       slope;
    logic [bag_pkg::ATK_W-1:0]        attack_step_select;
    logic [bag_pkg::REL_W-1:0]        release_step_select;
    logic [7:0]                       rdata;
    logic [bag_pkg::SAMPLE_W-1:0]     spk;
    logic [5:0]                       edge_ns;
  } bag_state_t;

  bag_state_t q;
  bag_state_t d;

  logic [19:0] infl_10uv;
  logic [22:0] vbat_10uv;
  logic [16:0] slope_val;
  logic [19:0] below_10uv;
  logic [39:0] drop_prod;
  logic [39:0] drop_mv;
  logic [15:0] limit_calc;
  logic        above_infl;
  logic        over_limit;
  logic [TW-1:0] atk_cyc;
  logic [TW-1:0] rel_cyc;
  logic [TW-1:0] interval;
  logic        restart;
  logic        tick;

  // Limit curve: flat at boost above the knee, sloped below it
  always_comb begin
    infl_10uv  = bag_pkg::INFL_BASE_10UV
               + 20'(q.infl * bag_pkg::INFL_STEP_10UV);            // see RULE_05
    vbat_10uv  = 23'(vbat_mv_i) * 23'(bag_pkg::MV_TO_10UV);        // Widen before the product
    slope_val  = bag_pkg::SLOPE_BASE
               + 17'(q.slope * bag_pkg::SLOPE_STEP);               // see RULE_06
    above_infl = vbat_10uv > 23'(infl_10uv);
    below_10uv = above_infl ? 20'h00000 : 20'(23'(infl_10uv) - vbat_10uv);
    drop_prod  = 40'(below_10uv) * 40'(slope_val);
    drop_mv    = drop_prod / bag_pkg::PROD_TO_MV;
    if (above_infl) begin
      limit_calc = vboost_mv_i;                                    // see RULE_04
    end else if (drop_mv >= 40'(vboost_mv_i)) begin
      limit_calc = 16'h0000;
    end else begin
      limit_calc = 16'(40'(vboost_mv_i) - drop_mv);                // see RULE_06
    end
  end

  // Only the output level decides an attack; battery only moves the limit
  assign over_limit = out_peak_mv_i > q.limit_mv;                  // see RULE_03

  // Step intervals in clock cycles from the two codes
  assign atk_cyc = TW'(ATK_BASE_CYC + ATK_STEP_CYC * 32'(q.attack_step_select));  // see RULE_09
  assign rel_cyc = TW'(REL_BASE_CYC + REL_STEP_CYC * 32'(q.release_step_select)); // see RULE_10
  assign interval = (q.st == bag_pkg::BAG_ATTACK) ? atk_cyc : rel_cyc;

  // Timer restarts on any change of direction and idles while holding
  // Built from registered state and inputs, not from the tick, so the tick never loops back into it
  assign restart = (q.st == bag_pkg::BAG_ATTACK)  ? !over_limit
                 : (q.st == bag_pkg::BAG_RELEASE) ? (over_limit || q.cur_gain >= fixed_gain_i)
                 : 1'b1;

  bag_step_timer #(
    .CW (TW)
  ) u_timer (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .restart_i  (restart),
    .interval_i (interval),
    .tick_o     (tick)
  );

  // Next state: registers, gain stepping, mux and edge decode
  always_comb begin
    d = q;
    d.limit_mv = limit_calc;
    d.spk      = src_digital_i ? digital_sample_i : analog_sample_i; // see RULE_02
    d.edge_ns  = bag_pkg::EDGE_NS_TABLE[edge_slew_control_i];        // see RULE_11

    // Register writes
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        bag_pkg::ADDR_INFL:    d.infl  = reg_wdata_i;                  // see RULE_05
        bag_pkg::ADDR_SLOPE:   d.slope = reg_wdata_i;                  // see RULE_06
        bag_pkg::ADDR_ATTACK:
          d.attack_step_select = reg_wdata_i[bag_pkg::ATK_LSB +: bag_pkg::ATK_W];
        bag_pkg::ADDR_RELEASE:
          d.release_step_select = reg_wdata_i[bag_pkg::REL_LSB +: bag_pkg::REL_W];
        default: ;
      endcase
    end

    // Register reads; unmapped offsets read zero
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        bag_pkg::ADDR_INFL:      d.rdata = q.infl;
        bag_pkg::ADDR_SLOPE:     d.rdata = q.slope;
        bag_pkg::ADDR_ATTACK:    d.rdata = {5'h00, q.attack_step_select};
        bag_pkg::ADDR_RELEASE:   d.rdata = {4'h0, q.release_step_select};
        bag_pkg::ADDR_GAIN_STAT: d.rdata = {3'h0, q.cur_gain};
        default:                 d.rdata = 8'h00;
      endcase
    end

    // Gain state machine
    unique case (q.st)
      bag_pkg::BAG_INIT: begin
        d.cur_gain = fixed_gain_i;                                      // see RULE_13
        d.st       = bag_pkg::BAG_HOLD;
      end
      bag_pkg::BAG_HOLD, bag_pkg::BAG_ATTACK, bag_pkg::BAG_RELEASE: begin
        if (q.st == bag_pkg::BAG_ATTACK && over_limit && tick
            && q.cur_gain != 5'h00) begin
          d.cur_gain = q.cur_gain - 5'h01;                              // see RULE_07
        end
        if (q.st == bag_pkg::BAG_RELEASE && !over_limit && tick
            && q.cur_gain < fixed_gain_i) begin
          d.cur_gain = q.cur_gain + 5'h01;                              // see RULE_08
        end
        if (over_limit) begin
          d.st = bag_pkg::BAG_ATTACK;                                   // see RULE_03
        end else if (q.cur_gain < fixed_gain_i) begin
          d.st = bag_pkg::BAG_RELEASE;
        end else begin
          d.st = bag_pkg::BAG_HOLD;
        end
        // Lowering the fixed gain pulls the working gain down at once
        if (d.cur_gain > fixed_gain_i) begin
          d.cur_gain = fixed_gain_i;                                    // see RULE_13
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q.st                  <= bag_pkg::BAG_INIT;
      q.cur_gain            <= 5'h00;
      q.limit_mv            <= 16'h0000;
      q.infl                <= bag_pkg::RST_INFL;
      q.slope               <= bag_pkg::RST_SLOPE;
      q.attack_step_select  <= bag_pkg::RST_ATTACK;
      q.release_step_select <= bag_pkg::RST_RELEASE;
      q.rdata               <= 8'h00;
      q.spk                 <= 16'h0000;
      q.edge_ns             <= 6'h00;
    end else begin
      q <= d;
    end
  end

  // Outputs, all from flip-flops except the dB view of the code and the active flag decoded from the state
  assign reg_rdata_o         = q.rdata;
  assign spk_sample_o        = q.spk;
  assign gain_code_o         = q.cur_gain;
  assign gain_db_o           = $signed({1'b0, q.cur_gain})
                             - $signed(bag_pkg::GAIN_OFFSET_DB);        // see RULE_01
  assign peak_output_limit_o = q.limit_mv;
  assign edge_time_ns_o      = q.edge_ns;
  assign agc_active_o        = (q.st == bag_pkg::BAG_ATTACK)
                            || (q.st == bag_pkg::BAG_RELEASE);

  // Checks on the documented behaviour
  a_gain_db_map: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_01
    gain_code_o == 5'h1f |-> gain_db_o == 6'sd24)
    else $error("top gain code not at +24 dB");

  a_src_single: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_02
    src_digital_i ##1 1'b1 |-> spk_sample_o == $past(digital_sample_i))
    else $error("digital source not routed");

  a_no_drop_low: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_03
    (q.st != bag_pkg::BAG_INIT && !over_limit && fixed_gain_i == $past(fixed_gain_i))
      |=> gain_code_o >= $past(gain_code_o))
    else $error("gain lowered without overload");

  a_limit_boost: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_04
    above_infl |=> peak_output_limit_o == $past(vboost_mv_i))
    else $error("limit not at boost above knee");

  a_infl_store: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_05
    (reg_wr_i && reg_addr_i == bag_pkg::ADDR_INFL)
      ##1 (reg_rd_i && !reg_wr_i && reg_addr_i == bag_pkg::ADDR_INFL)
      |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("inflection field not held");

  a_slope_below: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_06
    !above_infl |=> peak_output_limit_o <= $past(vboost_mv_i))
    else $error("sloped limit above boost");

  a_attack_step: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_07
    (q.st == bag_pkg::BAG_ATTACK && over_limit && tick && gain_code_o != 5'h00)
      |=> gain_code_o == $past(gain_code_o) - 5'h01)
    else $error("attack did not step down one dB");

  a_release_step: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_08
    (q.st == bag_pkg::BAG_RELEASE && !over_limit && tick && gain_code_o < fixed_gain_i)
      |=> gain_code_o == $past(gain_code_o) + 5'h01)
    else $error("release did not step up one dB");

  a_atk_fast: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_09
    q.attack_step_select == 3'h0 |-> atk_cyc == TW'(ATK_BASE_CYC))
    else $error("fastest attack interval wrong");

  a_edge_slow: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_11
    edge_slew_control_i == 3'h0 |=> edge_time_ns_o == 6'h32)
    else $error("edge code zero not slowest");

  a_gain_cap: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_13
    q.st != bag_pkg::BAG_INIT |=> gain_code_o <= $past(fixed_gain_i))
    else $error("gain above fixed setting");

endmodule // bag_gain_ctrl

// ===== hw/bag_step_timer.sv
// Step interval timer: one tick each time the interval elapses
`timescale 1ns/1ps
module bag_step_timer #(
  parameter int unsigned CW = 26
) (
  // Clock and reset
  input  wire logic          mclk_i,
  input  wire logic          rst_i,
  // Control
  input  wire logic          restart_i,
  input  wire logic [CW-1:0] interval_i,
  // Event
  output logic               tick_o
);

  typedef struct packed {
    logic [CW-1:0] cnt;
  } bag_timer_t;

  bag_timer_t q;
  bag_timer_t d;

  // Tick on the last cycle of the interval, then start over
  always_comb begin
    d = q;
    tick_o = 1'b0;
    if (restart_i) begin
      d.cnt = '0;
    end else if (q.cnt >= interval_i - CW'(1)) begin
      tick_o = 1'b1;  // see RULE_12
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + CW'(1);
    end
  end

  // State register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  a_tick_restart: assert property (@(posedge mclk_i) disable iff (rst_i)
    tick_o |=> q.cnt == '0) else $error("timer did not restart after tick"); // RULE_12

endmodule // bag_step_timer

// ===== shared/bag_pkg.sv
// Shared constants and types for the battery tracking gain block
package bag_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_INFL      = 8'h0b;
  localparam logic [7:0] ADDR_SLOPE     = 8'h0c;
  localparam logic [7:0] ADDR_ATTACK    = 8'h0e;
  localparam logic [7:0] ADDR_RELEASE   = 8'h0f;
  localparam logic [7:0] ADDR_GAIN_STAT = 8'h1a;

  // Field positions and widths
  localparam int unsigned ATK_LSB   = 0;
  localparam int unsigned ATK_W     = 3;
  localparam int unsigned REL_LSB   = 0;
  localparam int unsigned REL_W     = 4;
  localparam int unsigned GAIN_W    = 5;
  localparam int unsigned LEVEL_W   = 16;
  localparam int unsigned SAMPLE_W  = 16;

  // Reset values
  localparam logic [7:0]        RST_INFL    = 8'h00;
  localparam logic [7:0]        RST_SLOPE   = 8'h00;
  localparam logic [ATK_W-1:0]  RST_ATTACK  = 3'h0;
  localparam logic [REL_W-1:0]  RST_RELEASE = 4'h0;

  // Gain code 0 stands for -7 dB
  localparam logic [5:0] GAIN_OFFSET_DB = 6'h07;

  // Inflection point in 10 uV units: 3.0 V base, 17.33 mV step
  localparam logic [19:0] INFL_BASE_10UV = 20'h493e0;
  localparam logic [19:0] INFL_STEP_10UV = 20'h006c5;
  // Slope in 1e-4 V/V units: 1.2 V/V base, 37.3 mV/V step
  localparam logic [16:0] SLOPE_BASE     = 17'h02ee0;
  localparam logic [16:0] SLOPE_STEP     = 17'h00175;
  // Battery mV to 10 uV units, and product scale back to mV
  localparam logic [6:0]  MV_TO_10UV     = 7'h64;
  localparam logic [39:0] PROD_TO_MV     = 40'h00000f4240;

  // Step times: attack in us per dB, release in ms per dB
  localparam int unsigned ATK_BASE_US = 32'h00000014;
  localparam int unsigned ATK_STEP_US = 32'h0000015e;
  localparam int unsigned REL_BASE_MS = 32'h00000032;
  localparam int unsigned REL_STEP_MS = 32'h00000069;
  localparam int unsigned CLK_HZ      = 32'h01312d00;
  localparam int unsigned CYC_PER_US  = CLK_HZ / 32'h000f4240;
  localparam int unsigned CYC_PER_MS  = CLK_HZ / 32'h000003e8;
  localparam int unsigned ATK_BASE_CYC = ATK_BASE_US * CYC_PER_US;
  localparam int unsigned ATK_STEP_CYC = ATK_STEP_US * CYC_PER_US;
  localparam int unsigned REL_BASE_CYC = REL_BASE_MS * CYC_PER_MS;
  localparam int unsigned REL_STEP_CYC = REL_STEP_MS * CYC_PER_MS;
  localparam int unsigned TIMER_W      = 26;

  // Typical switching edge time in ns, indexed by edge code
  localparam logic [7:0][5:0] EDGE_NS_TABLE = {
    6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h19, 6'h1e, 6'h28, 6'h32
  };

  // Gain control states
  typedef enum logic [1:0] {
    BAG_INIT,
    BAG_HOLD,
    BAG_ATTACK,
    BAG_RELEASE
  } bag_agc_st_t;

endpackage

// ===== verification/tb.sv
// Self-checking testbench for the battery tracking gain block
`timescale 1ns/1ps
module tb;
  // Short step counts keep the gain ramps brief
  localparam int unsigned AB = 4, AS = 2, RB = 8, RS = 4;
  logic        mclk_i = 1'b0, rst_i = 1'b1;
  logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0, src_digital_i = 1'b0, agc_active_o;
  logic [4:0]  fixed_gain_i = 5'h1f, gain_code_o;
  logic [2:0]  edge_slew_control_i = 3'h0;
  logic [15:0] analog_sample_i = 16'h1234, digital_sample_i = 16'hbeef;
  logic [15:0] vbat_mv_i = 16'h1770, vboost_mv_i = 16'h1388, out_peak_mv_i = 16'h0000;
  logic [15:0] spk_sample_o, peak_output_limit_o;
  logic signed [5:0] gain_db_o;
  logic [5:0]  edge_time_ns_o;
  int          bad_count = 0, cmp_count = 0, cyc = 0, n;

  bag_gain_ctrl #(.ATK_BASE_CYC(AB), .ATK_STEP_CYC(AS), .REL_BASE_CYC(RB),
                  .REL_STEP_CYC(RS)) DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .fixed_gain_i(fixed_gain_i), .src_digital_i(src_digital_i),
    .edge_slew_control_i(edge_slew_control_i), .analog_sample_i(analog_sample_i),
    .digital_sample_i(digital_sample_i), .vbat_mv_i(vbat_mv_i), .vboost_mv_i(vboost_mv_i),
    .out_peak_mv_i(out_peak_mv_i), .spk_sample_o(spk_sample_o), .gain_code_o(gain_code_o),
    .gain_db_o(gain_db_o), .peak_output_limit_o(peak_output_limit_o),
    .edge_time_ns_o(edge_time_ns_o), .agc_active_o(agc_active_o));

  // 20 MHz clock
  always #25 mclk_i = ~mclk_i;

  // Hang guard; the full run needs well under this many cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Settle: let registered outputs follow a changed input
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    reg_addr_i <= a; reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk({8'h00, reg_rdata_o}, {8'h00, e});
  endtask

  // Cycles until the working gain next moves
  task automatic gap(output int k);
    logic [4:0] g;
    g = gain_code_o;
    k = 0;
    while (gain_code_o === g && k < 3000) begin
      @(posedge mclk_i);
      #1;
      k++;
    end
  endtask

  task automatic t_regs();
    rd(8'h0b, 8'h00); rd(8'h0c, 8'h00); rd(8'h0e, 8'h00); rd(8'h0f, 8'h00);
    wr(8'h0b, 8'ha5); wr(8'h0c, 8'h5a);
    rd(8'h0b, 8'ha5);
    rd(8'h0c, 8'h5a);
    wr(8'h0e, 8'hff); wr(8'h0f, 8'hff);
    rd(8'h0e, 8'h07);
    rd(8'h0f, 8'h0f);
    wr(8'h33, 8'h77);
    rd(8'h33, 8'h00);
    rd(8'h1a, 8'h1f);
    // Write then read the knee back to back
    @(posedge mclk_i) begin
      reg_addr_i <= 8'h0b;
      reg_wdata_i <= 8'h3c;
      reg_wr_i <= 1'b1;
    end
    @(posedge mclk_i) begin
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b1;
    end
    @(posedge mclk_i) reg_rd_i <= 1'b0;
    #1;
    chk({8'h00, reg_rdata_o}, 16'h003c);
    wr(8'h0b, 8'h00); wr(8'h0c, 8'h00); wr(8'h0e, 8'h00); wr(8'h0f, 8'h00);
  endtask

  task automatic t_mux_edge();
    for (int s = 0; s < 2; s++) begin
      @(posedge mclk_i) src_digital_i <= s[0];
      tick(2);
      chk(spk_sample_o, s ? 16'hbeef : 16'h1234);
    end
    for (int c = 0; c < 8; c++) begin
      @(posedge mclk_i) edge_slew_control_i <= c[2:0];
      tick(2);
      chk({10'h0, edge_time_ns_o}, {10'h0, 6'(c==0 ? 50 : c==1 ? 40 : c==2 ? 30 :
          c==3 ? 25 : 18 - c)});
    end
  endtask

  // Knee at 3000 mV with boost 5000 mV
  task automatic t_limit();
    tick(2);
    chk(peak_output_limit_o, 16'd5000);
    @(posedge mclk_i) vbat_mv_i <= 16'd2000;
    tick(2);
    chk(peak_output_limit_o, 16'd3800);
    wr(8'h0c, 8'h0a);
    tick(2);
    chk(peak_output_limit_o, 16'd3427);
    wr(8'h0b, 8'h01);
    tick(2);
    chk(peak_output_limit_o, 16'd3400);
    tick(20);
    chk({11'h0, agc_active_o, gain_code_o}, 16'h001f);
    @(posedge mclk_i) vbat_mv_i <= 16'd6000;
    tick(2);
  endtask

  task automatic t_attack();
    @(posedge mclk_i) out_peak_mv_i <= 16'd6000;
    tick(2);
    chk({15'h0, agc_active_o}, 16'h0001);
    gap(n); gap(n);
    chk(16'(n), 16'(AB));
    wr(8'h0e, 8'h07);
    gap(n); gap(n);
    chk(16'(n), 16'(AB + 7 * AS));
    chk(16'(gain_code_o), 16'd27);
    wr(8'h0e, 8'h00);
    for (int i = 0; i < 40 && gain_code_o !== 5'h00; i++) gap(n);
    tick(30);
    chk({11'h0, gain_code_o}, 16'h0000);
  endtask

  task automatic t_release();
    @(posedge mclk_i) out_peak_mv_i <= 16'd100;
    gap(n); gap(n);
    chk(16'(n), 16'(RB));
    wr(8'h0f, 8'h0f);
    gap(n); gap(n);
    chk(16'(n), 16'(RB + 15 * RS));
    for (int i = 0; i < 40 && gain_code_o !== 5'h1f; i++) gap(n);
    tick(200);
    chk({11'h0, gain_code_o}, 16'h001f);
  endtask

  task automatic t_gain_db();
    for (int g = 31; g >= 0; g--) begin
      @(posedge mclk_i) fixed_gain_i <= g[4:0];
      tick(3);
      chk({11'h0, gain_code_o}, 16'(g));
      chk({10'h0, gain_db_o}, {10'h0, 6'(g - 7)});
    end
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    tick(3);
    chk({11'h0, gain_code_o}, 16'h001f);
    t_regs();
    t_mux_edge();
    t_limit();
    t_attack();
    t_release();
    t_gain_db();
    end_sim();
  end
endmodule // tb
